// ==== pkg/ptc_pkg.sv ====
// package: offsets, field layout, reset values and timing of the pack topology register
package ptc_pkg;
  // register map
  localparam logic [7:0] PTC_OFFSET = 8'h18;
  // field positions
  localparam int FLEX_B_BIT = 15;
  localparam int FLEX_A_BIT = 14;
  localparam int SCAN_DLY_BIT = 13;
  localparam int UNUSED_BIT = 12;
  localparam int BLOCK_LSB = 8;
  localparam int CELL_B_LSB = 4;
  localparam int CELL_A_LSB = 0;
  // reset values
  localparam logic [15:0] PTC_RESET = 16'hefff;
  // supported top-cell / top-block range
  localparam logic [3:0] SEL_MIN = 4'h8;
  localparam logic [3:0] SEL_MAX = 4'he;
  localparam logic [3:0] SEL_BLOCK_PIN = 4'hf;
  // settle delay before sampling the top cell
  localparam int SETTLE_NS = 30000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  // stored register fields
  typedef struct packed {
    logic flex_enable_copy_b;
    logic flex_enable_copy_a;
    logic alt_scan_settle_delay;
    logic [3:0] block_top_select;
    logic [3:0] cell_top_select_b;
    logic [3:0] cell_top_select_a;
  } ptc_fields_s;

  // effective analog mux controls
  typedef struct packed {
    logic [6:0] supply_pin_switch_mux;
    logic supply_common_switch;
    logic [3:0] block_divider_mux;
  } ptc_mux_s;
endpackage

// ==== verif/ptc_props.sv ====
// checker: port-level properties of the pack topology register
`timescale 1ns/10ps
// ==========================================================
// property checker
module ptc_props
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_ACK,
  input wire logic ALT_SCAN_START,
  input wire logic TOP_SAMPLE_GO,
  input wire logic FLEX_ENGAGED,
  input wire logic [6:0] SUPPLY_SWITCH_SEL,
  input wire logic SUPPLY_COMMON_SWITCH,
  input wire logic [3:0] BLOCK_DIVIDER_SEL,
  input wire logic CELL_TOP_AGREED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [15:0] wd_r; // data of the latest write, for the mux checks
  // capture write data so the consequent two edges later can use it
  always_ff @(posedge CLK)
  begin
    if (REG_WR)
    begin
      wd_r <= REG_WDATA;
    end
  end
  // a write taken at the mapped offset
  sequence s_wr;
    REG_WR && REG_ADDR == ptc_pkg::PTC_OFFSET;
  endsequence
  property p_ack; (REG_WR || REG_RD) |=> REG_ACK; endproperty
  property p_common; SUPPLY_COMMON_SWITCH; endproperty
  property p_flex_dis; s_wr ##0 (REG_WDATA[15] != REG_WDATA[14])
    |-> ##2 FLEX_ENGAGED && SUPPLY_SWITCH_SEL == 7'h00; endproperty
  property p_flex_off; s_wr ##0 (REG_WDATA[15:14] == 2'b00)
    |-> ##2 !FLEX_ENGAGED && BLOCK_DIVIDER_SEL == 4'hf; endproperty
  property p_cell_sel; s_wr ##0 (REG_WDATA[15:14] == 2'b11 && REG_WDATA[7:4] == REG_WDATA[3:0]
    && REG_WDATA[3:0] >= 4'h8 && REG_WDATA[3:0] <= 4'he)
    |-> ##2 SUPPLY_SWITCH_SEL == 7'(7'h01 << (wd_r[3:0] - 4'h8)); endproperty
  property p_block; s_wr ##0 (REG_WDATA[15:14] == 2'b11)
    |-> ##2 BLOCK_DIVIDER_SEL == ((wd_r[11:8] >= 4'h8) ? wd_r[11:8] : 4'hf); endproperty
  property p_cell_dis; s_wr ##0 (REG_WDATA[7:4] != REG_WDATA[3:0])
    |-> ##2 !CELL_TOP_AGREED && SUPPLY_SWITCH_SEL == 7'h00; endproperty
  property p_bit12; REG_RD |=> !REG_RDATA[12]; endproperty
  // a start in the strobe cycle may legally give a second, immediate strobe
  property p_go_pulse; TOP_SAMPLE_GO && !ALT_SCAN_START |=> !TOP_SAMPLE_GO; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_common: assert property (p_common) else $error("common switch open");
  a_flex_dis: assert property (p_flex_dis) else $error("flex mismatch");
  a_flex_off: assert property (p_flex_off) else $error("flex off");
  a_cell_sel: assert property (p_cell_sel) else $error("cell switch");
  a_block: assert property (p_block) else $error("block divider");
  a_cell_dis: assert property (p_cell_dis) else $error("cell mismatch");
  a_bit12: assert property (p_bit12) else $error("unused bit set");
  a_go_pulse: assert property (p_go_pulse) else $error("go too long");
endmodule
bind ptc_top ptc_props i_ptc_props (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REG_ACK(REG_ACK), .ALT_SCAN_START(ALT_SCAN_START),
  .TOP_SAMPLE_GO(TOP_SAMPLE_GO), .FLEX_ENGAGED(FLEX_ENGAGED),
  .SUPPLY_SWITCH_SEL(SUPPLY_SWITCH_SEL), .SUPPLY_COMMON_SWITCH(SUPPLY_COMMON_SWITCH),
  .BLOCK_DIVIDER_SEL(BLOCK_DIVIDER_SEL), .CELL_TOP_AGREED(CELL_TOP_AGREED));

// ==== verif/ptc_top_bench.sv ====
// testbench: register access, mux decoding and scan delay of the pack topology block
`timescale 1ns/10ps
// ==========================================================
// bench
module ptc_top_bench;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h18;
  logic [15:0] REG_WDATA = 16'h0000;
  logic ALT_SCAN_START = 1'b0;
  logic [15:0] REG_RDATA;
  logic REG_ACK, TOP_SAMPLE_GO, FLEX_ENGAGED, SUPPLY_COMMON_SWITCH, CELL_TOP_AGREED;
  logic [6:0] SUPPLY_SWITCH_SEL;
  logic [3:0] BLOCK_DIVIDER_SEL, CELL_TOP_VALUE;
  int n_errors = 0;
  int n_tests = 0;
  always #5 CLK = ~CLK;
  ptc_top i_ptc_top (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .ALT_SCAN_START(ALT_SCAN_START), .TOP_SAMPLE_GO(TOP_SAMPLE_GO),
    .FLEX_ENGAGED(FLEX_ENGAGED), .SUPPLY_SWITCH_SEL(SUPPLY_SWITCH_SEL),
    .SUPPLY_COMMON_SWITCH(SUPPLY_COMMON_SWITCH), .BLOCK_DIVIDER_SEL(BLOCK_DIVIDER_SEL),
    .CELL_TOP_AGREED(CELL_TOP_AGREED), .CELL_TOP_VALUE(CELL_TOP_VALUE));
  // compare one value and count it
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // print counts and the verdict
  task end_sim;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one write, then one more edge so the mux outputs settle
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
    chk("ack", {15'h0000, REG_ACK}, 16'h0001);
    @(negedge CLK);
  endtask
  // one read with its expected word
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    chk("rdata", REG_RDATA, e);
  endtask
  // effective mux controls
  task mux(input logic f, input logic [6:0] s, input logic [3:0] b);
    chk("flex", {15'h0000, FLEX_ENGAGED}, {15'h0000, f});
    chk("sw", {9'h000, SUPPLY_SWITCH_SEL}, {9'h000, s});
    chk("blk", {12'h000, BLOCK_DIVIDER_SEL}, {12'h000, b});
    chk("com", {15'h0000, SUPPLY_COMMON_SWITCH}, 16'h0001);
  endtask
  // every cell and block code with agreeing copies
  task t_sweep;
    logic [3:0] v;
    logic ok;
    for (int i = 0; i < 16; i++)
    begin
      v = i[3:0];
      ok = (v >= 4'h8) && (v <= 4'he);
      wr(8'h18, {4'hc, v, v, v});
      mux(1'b1, ok ? 7'(7'h01 << (v - 4'h8)) : 7'h00, ok ? v : 4'hf);
    end
  endtask
  // copies of the enable disagree either way, then both zero
  task t_flex;
    for (int i = 1; i < 3; i++)
    begin
      wr(8'h18, {i[1:0], 14'h0999});
      mux(1'b1, 7'h00, 4'h9);
    end
    wr(8'h18, 16'h0999);
    mux(1'b0, 7'h00, 4'hf);
  endtask
  // cell copies disagree, then an unmapped access
  task t_cells;
    wr(8'h18, 16'hc9a9);
    chk("agree", {15'h0000, CELL_TOP_AGREED}, 16'h0000);
    chk("cell", {12'h000, CELL_TOP_VALUE}, 16'h0009);
    mux(1'b1, 7'h00, 4'h9);
    wr(8'h19, 16'h0000);
    rd(8'h18, 16'hc9a9);
    rd(8'h19, 16'h0000);
  endtask
  // reset in mid-run brings every field back to its default
  task t_reset;
    wr(8'h18, 16'h0999);
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
    rd(8'h18, 16'hefff);
    mux(1'b1, 7'h00, 4'hf);
  endtask
  // scan start and count the cycles to the sample strobe
  task t_scan(input logic [15:0] d, input int e);
    int k;
    wr(8'h18, d);
    @(negedge CLK);
    ALT_SCAN_START = 1'b1;
    for (k = 1; k <= 4000; k++)
    begin
      @(negedge CLK);
      ALT_SCAN_START = 1'b0;
      if (TOP_SAMPLE_GO === 1'b1)
        break;
    end
    chk("go", k[15:0], e[15:0]);
    if (k > 4000)
      end_sim;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge CLK);
    @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
    rd(8'h18, 16'hefff);
    mux(1'b1, 7'h00, 4'hf);
    wr(8'h18, 16'hffff);
    rd(8'h18, 16'hefff);
    t_sweep;
    t_flex;
    t_cells;
    t_reset;
    t_scan(16'he999, 3000);
    t_scan(16'hc999, 1);
    end_sim;
  end
endmodule

// ==== verilog/ptc_top.sv ====
// pack topology configuration register and its effective mux controls
`timescale 1ns/10ps
// =====================================================================
// Contract
// - each enable copy: 0 off, 1 on, resets 1
// - effective enable is common value when copies agree
// - copies disagree: effective enable forced to one
// - copies disagree: supply switch mux forced off
// - agreed top cell 0x8..0xE picks cells 8..14
// - unsupported top cell: individual switches open, common closed
// - top block 0x8..0xE picks divider cells 8..14
// - unsupported top block routes divider to block pin
// - engaged flex selects internal power and block path
// - scan delay, block, cell copies reset 1,F,F,F
// - cell copies disagree: no alert masking, supply off
// - top block ignored when effective enable is zero
// - delayed alt scan waits 30 us before sampling; here only with flex engaged and a supported agreed top cell, else at once
module ptc_top
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic ALT_SCAN_START,
  output logic TOP_SAMPLE_GO,
  output logic FLEX_ENGAGED,
  output logic [6:0] SUPPLY_SWITCH_SEL,
  output logic SUPPLY_COMMON_SWITCH,
  output logic [3:0] BLOCK_DIVIDER_SEL,
  output logic CELL_TOP_AGREED,
  output logic [3:0] CELL_TOP_VALUE
);

  // =====================================================================
  // reset release
  logic rst_s1_r; // first stage of reset release
  logic rst_n_r; // released reset used by the design

  // async assert, two-flop release
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // =====================================================================
  // helpers
  // true for a supported cell / block code
  function automatic logic sel_ok(input logic [3:0] s);
    sel_ok = (s >= ptc_pkg::SEL_MIN) && (s <= ptc_pkg::SEL_MAX);
  endfunction

  // =====================================================================
  // register storage
  ptc_pkg::ptc_fields_s cfg_r; // stored fields
  ptc_pkg::ptc_fields_s cfg_nxt; // next stored fields
  logic [15:0] rdata_r; // read data register
  logic [15:0] rdata_nxt; // next read data
  logic ack_r; // access acknowledge
  logic ack_nxt; // next acknowledge
  logic hit; // address decode
  logic [15:0] reg_view; // register as software sees it

  // stored fields packed back with bit 12 forced low
  always_comb
  begin
    reg_view = 16'h0000;
    reg_view[ptc_pkg::FLEX_B_BIT] = cfg_r.flex_enable_copy_b;
    reg_view[ptc_pkg::FLEX_A_BIT] = cfg_r.flex_enable_copy_a;
    reg_view[ptc_pkg::SCAN_DLY_BIT] = cfg_r.alt_scan_settle_delay;
    reg_view[ptc_pkg::UNUSED_BIT] = 1'b0;
    reg_view[ptc_pkg::BLOCK_LSB +: 4] = cfg_r.block_top_select;
    reg_view[ptc_pkg::CELL_B_LSB +: 4] = cfg_r.cell_top_select_b;
    reg_view[ptc_pkg::CELL_A_LSB +: 4] = cfg_r.cell_top_select_a;
  end

  // write, read and acknowledge next values
  always_comb
  begin
    hit = (REG_ADDR == ptc_pkg::PTC_OFFSET);
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    ack_nxt = REG_WR || REG_RD;
    if (REG_WR && hit)
    begin
      // every field writable; bit 12 dropped
      cfg_nxt.flex_enable_copy_b = REG_WDATA[ptc_pkg::FLEX_B_BIT];
      cfg_nxt.flex_enable_copy_a = REG_WDATA[ptc_pkg::FLEX_A_BIT];
      cfg_nxt.alt_scan_settle_delay = REG_WDATA[ptc_pkg::SCAN_DLY_BIT];
      cfg_nxt.block_top_select = REG_WDATA[ptc_pkg::BLOCK_LSB +: 4];
      cfg_nxt.cell_top_select_b = REG_WDATA[ptc_pkg::CELL_B_LSB +: 4];
      cfg_nxt.cell_top_select_a = REG_WDATA[ptc_pkg::CELL_A_LSB +: 4];
    end
    if (REG_RD)
    begin
      // unmapped addresses read as zero
      rdata_nxt = hit ? reg_view : 16'h0000;
    end
  end

  // register the storage
  always_ff @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      // bit 12 has no storage: drop it so every field keeps its place
      cfg_r <= ptc_pkg::ptc_fields_s'({ptc_pkg::PTC_RESET[15:13],
                                       ptc_pkg::PTC_RESET[11:0]});
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  // =====================================================================
  // effective controls
  logic flex_agree; // enable copies match
  logic flex_eff; // effective flex enable
  logic cell_agree; // top-cell copies match
  logic cell_ok; // agreed top cell is supported
  ptc_pkg::ptc_mux_s mux_nxt; // next mux controls
  ptc_pkg::ptc_mux_s mux_r; // registered mux controls
  logic [3:0] cell_idx; // switch index for cells 8..14

  // decode redundant copies into mux controls
  always_comb
  begin
    flex_agree = (cfg_r.flex_enable_copy_a == cfg_r.flex_enable_copy_b);
    flex_eff = flex_agree ? cfg_r.flex_enable_copy_a : 1'b1;
    cell_agree = (cfg_r.cell_top_select_a == cfg_r.cell_top_select_b);
    cell_ok = cell_agree && sel_ok(cfg_r.cell_top_select_a);
    cell_idx = cfg_r.cell_top_select_a - ptc_pkg::SEL_MIN;
    // off position: individual switches open, common switch closed
    mux_nxt.supply_pin_switch_mux = 7'h00;
    mux_nxt.supply_common_switch = 1'b1;
    mux_nxt.block_divider_mux = ptc_pkg::SEL_BLOCK_PIN;
    if (flex_agree && flex_eff && cell_ok)
    begin
      mux_nxt.supply_pin_switch_mux = 7'h01 << cell_idx[2:0];
    end
    if (flex_eff && sel_ok(cfg_r.block_top_select))
    begin
      mux_nxt.block_divider_mux = cfg_r.block_top_select;
    end
  end

  // register mux controls and flex status
  logic flex_eff_r; // registered effective enable
  logic cell_agree_r; // registered cell agreement
  always_ff @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mux_r <= '{supply_pin_switch_mux: 7'h00, supply_common_switch: 1'b1,
                 block_divider_mux: ptc_pkg::SEL_BLOCK_PIN};
      flex_eff_r <= 1'b1;
      cell_agree_r <= 1'b1;
    end
    else
    begin
      mux_r <= mux_nxt;
      flex_eff_r <= flex_eff;
      cell_agree_r <= cell_agree;
    end
  end

  // =====================================================================
  // settle delay before top-cell sampling
  logic [ptc_pkg::CNT_W-1:0] cnt_r; // remaining settle cycles
  logic [ptc_pkg::CNT_W-1:0] cnt_nxt; // next count
  logic busy_r; // settle wait in progress
  logic busy_nxt; // next busy
  logic go_r; // sample strobe
  logic go_nxt; // next strobe

  // start, count down, then strobe the sample
  always_comb
  begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    go_nxt = 1'b0;
    if (busy_r)
    begin
      if (cnt_r == '0)
      begin
        busy_nxt = 1'b0;
        go_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
    else if (ALT_SCAN_START)
    begin
      if (cfg_r.alt_scan_settle_delay && flex_eff && cell_ok)
      begin
        busy_nxt = 1'b1;
        cnt_nxt = ptc_pkg::CNT_W'(ptc_pkg::SETTLE_CYCLES - 2);
      end
      else
      begin
        go_nxt = 1'b1; // no delay: sample at once
      end
    end
  end

  // register the delay state
  always_ff @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      go_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      go_r <= go_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign REG_RDATA = rdata_r;
  assign REG_ACK = ack_r;
  assign TOP_SAMPLE_GO = go_r;
  assign FLEX_ENGAGED = flex_eff_r;
  assign SUPPLY_SWITCH_SEL = mux_r.supply_pin_switch_mux;
  assign SUPPLY_COMMON_SWITCH = mux_r.supply_common_switch;
  assign BLOCK_DIVIDER_SEL = mux_r.block_divider_mux;
  assign CELL_TOP_AGREED = cell_agree_r;
  assign CELL_TOP_VALUE = cfg_r.cell_top_select_a;

endmodule
